// ===== mmc_pkg.sv
package mmc_pkg;
	// Register byte addresses: base config word, its clear, set and invert aliases, PHY address and status
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_CLR = 8'h04;
	localparam logic [7:0] ADDR_SET = 8'h08;
	localparam logic [7:0] ADDR_INV = 8'h0C;
	localparam logic [7:0] ADDR_PHY = 8'h10;
	localparam logic [7:0] ADDR_STS = 8'h14;
	// Field positions in the configuration word
	localparam int BIT_RST = 15;
	localparam int BIT_SEL_HI = 5;
	localparam int BIT_SEL_LO = 2;
	localparam int BIT_SUPPRESS_PREAMBLE = 1;
	localparam int BIT_SCAN = 0;
	// Writable bit mask and reset value
	localparam logic [15:0] CFG_MASK = 16'h803F;
	localparam logic [15:0] CFG_RESET = 16'h0020;
	localparam logic [4:0] PHY_FIRST = 5'h01;
	localparam logic [4:0] PHY_RESET = 5'h01;
	// Divider select codes
	localparam logic [3:0] SEL_D6 = 4'h2;
	localparam logic [3:0] SEL_D8 = 4'h3;
	localparam logic [3:0] SEL_D10 = 4'h4;
	localparam logic [3:0] SEL_D14 = 4'h5;
	localparam logic [3:0] SEL_D20 = 4'h6;
	localparam logic [3:0] SEL_D28 = 4'h7;
	localparam logic [3:0] SEL_D40 = 4'h8;
	localparam logic [3:0] SEL_D48 = 4'h9;
	localparam logic [3:0] SEL_D50 = 4'hA;
	// Half periods of the management clock, in bus clock cycles
	localparam logic [4:0] HALF_D4 = 5'h02;
	localparam logic [4:0] HALF_D6 = 5'h03;
	localparam logic [4:0] HALF_D8 = 5'h04;
	localparam logic [4:0] HALF_D10 = 5'h05;
	localparam logic [4:0] HALF_D14 = 5'h07;
	localparam logic [4:0] HALF_D20 = 5'h0A;
	localparam logic [4:0] HALF_D28 = 5'h0E;
	localparam logic [4:0] HALF_D40 = 5'h14;
	localparam logic [4:0] HALF_D48 = 5'h18;
	localparam logic [4:0] HALF_D50 = 5'h19;
	// Frame length: 32 preamble bits plus 32 frame bits
	localparam logic [6:0] PRE_BITS = 7'h20;
	localparam logic [6:0] FRAME_BITS = 7'h20;
	// Read frame fields: start and read opcode, scanned register, turnaround, data
	localparam logic [3:0] FRAME_HEAD = 4'h6;
	localparam logic [4:0] SCAN_REG = 5'h01;
	localparam logic [1:0] TA_IDLE = 2'h3;
	localparam logic [15:0] DATA_IDLE = 16'hFFFF;
	// Bit counts in the frame: last driven bit and data field length
	localparam logic [6:0] OE_LAST_CNT = 7'h12;
	localparam logic [6:0] DATA_BITS = 7'h10;
	typedef enum logic [1:0] {
		MMC_IDLE = 2'b00,
		MMC_PRE = 2'b01,
		MMC_FRAME = 2'b10
	} mmc_state_t;
endpackage : mmc_pkg

// ===== mmc_clkdiv.sv
`timescale 1ns/10ps
`default_nettype none
module mmc_clkdiv (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic soft_rst,
	// Half period in bus clock cycles
	input wire logic [4:0] half,
	// Management clock level and edge enables
	output logic mdc,
	output logic rise_en,
	output logic fall_en
);
	logic [4:0] cnt;
	wire last = (cnt >= half - 5'h01);
	// Half-period counter toggling the management clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 5'h00;
			mdc <= 1'b0;
			rise_en <= 1'b0;
			fall_en <= 1'b0;
		end else if (soft_rst) begin
			cnt <= 5'h00;
			mdc <= 1'b0;
			rise_en <= 1'b0;
			fall_en <= 1'b0;
		end else begin
			cnt <= last ? 5'h00 : cnt + 5'h01;
			mdc <= last ? ~mdc : mdc;
			rise_en <= last & ~mdc;
			fall_en <= last & mdc;
		end
	end
endmodule : mmc_clkdiv
`default_nettype wire

// ===== mmc_top.sv
// Summary of operation
// (RULE_01) Soft-reset bit high holds the management engine and divider in reset.
// (RULE_02) Select codes 000x, 0010, 0011 divide the bus clock by 4, 6, 8.
// (RULE_03) Codes 0100 to 0111 divide by 10, 14, 20, 28.
// (RULE_04) Codes 1000, 1001, 1010 divide by 40, 48, 50.
// (RULE_05) Software programs only the listed select codes; others are undefined.
// (RULE_06) Software keeps the management clock at 2.5 MHz unless PHY allows 12.5.
// (RULE_07) Suppress-preamble bit set drops the 32-bit preamble from every cycle.
// (RULE_08) Scan-increment set steps PHY address from 1 to programmed address.
// (RULE_09) Halfword and word accesses work, including aliases; byte accesses ignored.
// (RULE_10) Unimplemented configuration bits, including 31 to 16, read as zero.
// (RULE_11) Scanning wraps from the upper address back to 1 until disabled.
// (RULE_12) Select field resets to 1000, divide by 40.
`timescale 1ns/10ps
`default_nettype none
module mmc_top (
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Scan control
	input wire logic scan_enable,
	// Management link
	output logic mdc,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic mdio_in,
	// Status
	output logic [4:0] scan_phy,
	output logic [15:0] read_data,
	output logic read_valid
);
	import mmc_pkg::*;

	logic [15:0] cfg;
	logic [4:0] target_phy_address;
	logic [15:0] next_cfg;
	mmc_state_t state;
	logic [6:0] bit_cnt;
	logic [31:0] shreg;
	logic [15:0] rx;
	logic [2:0] mdio_sync;
	logic scan_en_q;
	logic [4:0] half;
	logic mdc_i;
	logic rise_en;
	logic fall_en;
	logic mdio_s;

	// Bus decode
	wire access = psel & penable;
	wire wr = access & pwrite;
	wire strb_ok = (pstrb == 4'b0011) | (pstrb == 4'b1100) | (pstrb == 4'b1111);
	wire wr_ok = wr & strb_ok; // [RULE_09]
	wire hit_cfg = (paddr == ADDR_CFG);
	wire hit_clr = (paddr == ADDR_CLR);
	wire hit_set = (paddr == ADDR_SET);
	wire hit_inv = (paddr == ADDR_INV);
	wire hit_phy = (paddr == ADDR_PHY);
	wire hit_sts = (paddr == ADDR_STS);
	wire hit_any = hit_cfg | hit_clr | hit_set | hit_inv | hit_phy | hit_sts;
	wire [15:0] wlo = pstrb[0] ? pwdata[15:0] : 16'h0000;
	wire [15:0] wv = wlo & CFG_MASK; // [RULE_10]
	wire soft_rst = cfg[BIT_RST]; // [RULE_01]
	wire [3:0] sel = cfg[BIT_SEL_HI:BIT_SEL_LO];
	wire suppress_preamble = cfg[BIT_SUPPRESS_PREAMBLE];
	wire scan_inc = cfg[BIT_SCAN];

	// Alias write selection: plain, clear, set, invert
	always_comb begin
		next_cfg = cfg;
		if (wr_ok & pstrb[0]) begin
			if (hit_cfg) begin
				next_cfg = wv;
			end else if (hit_clr) begin
				next_cfg = cfg & ~wv;
			end else if (hit_set) begin
				next_cfg = cfg | wv;
			end else if (hit_inv) begin
				next_cfg = cfg ^ wv;
			end
		end
	end

	// Divider half period from the select code
	always_comb begin
		case (sel)
			SEL_D6: half = HALF_D6; // [RULE_02]
			SEL_D8: half = HALF_D8; // [RULE_02]
			SEL_D10: half = HALF_D10; // [RULE_03]
			SEL_D14: half = HALF_D14; // [RULE_03]
			SEL_D20: half = HALF_D20; // [RULE_03]
			SEL_D28: half = HALF_D28; // [RULE_03]
			SEL_D40: half = HALF_D40; // [RULE_04]
			SEL_D48: half = HALF_D48; // [RULE_04]
			SEL_D50: half = HALF_D50; // [RULE_04]
			default: half = HALF_D4; // [RULE_02]
		endcase
	end

	// Configuration and PHY address registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= CFG_RESET; // [RULE_12]
			target_phy_address <= PHY_RESET;
		end else begin
			cfg <= next_cfg; // [RULE_09]
			if (wr_ok & pstrb[0] & hit_phy) begin
				target_phy_address <= pwdata[4:0];
			end
		end
	end

	// APB answer: one wait-free access phase, error on unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit_any;
			if (psel & ~penable & ~pwrite) begin
				if (hit_phy) begin
					prdata <= {27'h000_0000, target_phy_address};
				end else if (hit_sts) begin
					prdata <= {11'h000, scan_phy, read_data};
				end else if (hit_cfg) begin
					prdata <= {16'h0000, cfg}; // [RULE_10]
				end else begin
					prdata <= 32'h0000_0000;
				end
			end
		end
	end

	// Management clock divider
	mmc_clkdiv u_div (
		.pclk(pclk),
		.presetn(presetn),
		.soft_rst(soft_rst),
		.half(half),
		.mdc(mdc_i),
		.rise_en(rise_en),
		.fall_en(fall_en)
	);

	// Pin and scan input synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdio_sync <= 3'b000;
			mdio_s <= 1'b0;
			scan_en_q <= 1'b0;
		end else begin
			mdio_sync <= {mdio_sync[1:0], mdio_in};
			scan_en_q <= scan_enable;
			// Take a new level only once the last two stages agree
			if (mdio_sync[1] == mdio_sync[2]) begin
				mdio_s <= mdio_sync[2];
			end
		end
	end
	// Input filter costs four bus cycles, so the fastest dividers leave little margin

	// Read frame: start, read op, PHY address, scanned register, turnaround
	wire [31:0] frame = {FRAME_HEAD, scan_phy, SCAN_REG, TA_IDLE, DATA_IDLE};

	// Scanning read engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= MMC_IDLE;
			bit_cnt <= 7'h00;
			shreg <= 32'h0000_0000;
			rx <= 16'h0000;
			scan_phy <= PHY_FIRST;
			read_data <= 16'h0000;
			read_valid <= 1'b0;
			mdio_out <= 1'b1;
			mdio_oe <= 1'b0;
			mdc <= 1'b0;
		end else if (soft_rst) begin
			state <= MMC_IDLE; // [RULE_01]
			bit_cnt <= 7'h00;
			scan_phy <= PHY_FIRST;
			read_valid <= 1'b0;
			mdio_out <= 1'b1;
			mdio_oe <= 1'b0;
			mdc <= 1'b0;
		end else begin
			mdc <= mdc_i;
			read_valid <= 1'b0;
			case (state)
				MMC_IDLE: begin
					mdio_oe <= 1'b0;
					if (scan_en_q & fall_en) begin
						mdio_oe <= 1'b1;
						if (suppress_preamble) begin
							// First frame bit goes out at once, no preamble
							mdio_out <= frame[31];
							shreg <= {frame[30:0], 1'b0};
							bit_cnt <= FRAME_BITS - 7'h01; // [RULE_07]
							state <= MMC_FRAME;
						end else begin
							// This edge drives the first of the preamble ones
							mdio_out <= 1'b1;
							shreg <= frame;
							bit_cnt <= FRAME_BITS + PRE_BITS - 7'h01; // [RULE_07]
							state <= MMC_PRE;
						end
					end
				end
				MMC_PRE: begin
					if (fall_en) begin
						bit_cnt <= bit_cnt - 7'h01;
						if (bit_cnt == FRAME_BITS + 7'h01) begin
							state <= MMC_FRAME;
						end
					end
				end
				MMC_FRAME: begin
					if (fall_en) begin
						mdio_out <= shreg[31];
						shreg <= {shreg[30:0], 1'b0};
						mdio_oe <= (bit_cnt > OE_LAST_CNT);
						bit_cnt <= bit_cnt - 7'h01;
					end
					if (rise_en & (bit_cnt < DATA_BITS)) begin
						rx <= {rx[14:0], mdio_s};
					end
					// Last data bit joins the word in the same edge
					if (rise_en & (bit_cnt == 7'h00)) begin
						read_data <= {rx[14:0], mdio_s};
						read_valid <= 1'b1;
						state <= MMC_IDLE;
						if (scan_inc & (scan_phy < target_phy_address)) begin
							scan_phy <= scan_phy + 5'h01; // [RULE_08]
						end else begin
							scan_phy <= PHY_FIRST; // [RULE_11]
						end
					end
				end
				default: state <= MMC_IDLE;
			endcase
		end
	end
endmodule : mmc_top
`default_nettype wire

// ===== mmc_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module mmc_chk import mmc_pkg::*; (
	// Bus side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Link side
	input wire logic mdc,
	input wire logic mdio_oe,
	input wire logic [4:0] scan_phy
);
	logic rst_q;
	wire cfg_wr = psel && penable && pready && pwrite && paddr == ADDR_CFG && pstrb[1:0] == 2'b11;
	// Mirror of the soft-reset bit, tracked from plain config writes only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_q <= 1'b0;
		end else if (cfg_wr) begin
			rst_q <= pwdata[BIT_RST];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SETUP_READY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_UNMAPPED: assert property (psel && !penable && paddr > ADDR_STS |=> pslverr)
		else $error("unmapped access not flagged");
	AST_UPPER_ZERO: assert property (pready && !pwrite && paddr == ADDR_CFG
		|-> prdata[31:16] == 16'h0000 && prdata[14:6] == 9'h000)
		else $error("unused config bits not zero");
	AST_SOFT_MDC: assert property (rst_q [*3] |-> !mdc)
		else $error("clock runs in soft reset");
	AST_SOFT_OE: assert property (rst_q [*3] |-> !mdio_oe)
		else $error("link driven in soft reset");
	AST_SCAN_STEP: assert property ($changed(scan_phy)
		|-> scan_phy == $past(scan_phy) + 5'h01 || scan_phy == PHY_FIRST)
		else $error("scan address jumped");
	AST_MDC_HOLD: assert property ((!rst_q && $changed(mdc)) ##1 !rst_q |-> $stable(mdc))
		else $error("clock half period too short");
endmodule : mmc_chk
bind mmc_top mmc_chk u_mmc_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr, .mdc, .mdio_oe, .scan_phy);
`default_nettype wire

// ===== mmc_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
module mmc_phy_model (
	// Management link
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	output logic mdio_in
);
	localparam logic [15:0] PAT_SEED = 16'hA5C3;
	logic [15:0] pat = PAT_SEED;
	// Released line shows a pattern that moves every clock, never a held value
	// Pattern restarts while the device drives, so each read returns a known word
	always @(posedge mdc) pat <= mdio_oe ? PAT_SEED : {pat[14:0], pat[15]};
	assign mdio_in = mdio_oe ? mdio_out : pat[15];
endmodule : mmc_phy_model
`default_nettype wire

// ===== tb_mmc_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_mmc_top;
	import mmc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, scan_enable = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, mdc, mdio_out, mdio_oe, mdio_in, read_valid, er;
	logic [4:0] scan_phy;
	logic [15:0] read_data;
	int failures = 0, samples_checked = 0, cyc = 0, n, k;
	always #5 pclk = ~pclk;
	mmc_top u_mmc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .scan_enable, .mdc, .mdio_out, .mdio_oe, .mdio_in,
		.scan_phy, .read_data, .read_valid);
	mmc_phy_model u_mmc_phy_model (.mdc, .mdio_out, .mdio_oe, .mdio_in);
	task automatic report_and_stop;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	// One bus transfer, held until ready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? s : 4'h0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Cycles up to the next rising management clock
	task automatic rise(output int c);
		logic p;
		logic seen;
		c = 0;
		p = mdc;
		seen = 1'b0;
		while (!seen && c < 300) begin
			@(posedge pclk);
			c++;
			seen = (mdc === 1'b1 && p === 1'b0);
			p = mdc;
		end
	endtask : rise
	task automatic wt(input logic v);
		for (int i = 0; i < 5000 && mdio_oe !== v; i++) @(posedge pclk);
	endtask : wt
	task automatic t_regs;
		logic [7:0] ta[7] = '{ADDR_CFG, ADDR_CFG, ADDR_CFG, ADDR_CFG, ADDR_SET, ADDR_INV, ADDR_CLR};
		logic [31:0] td[7] = '{32'hFFFF_FFFF, 0, 0, 0, 32'h0000_0002, 32'h0000_0003, 32'h0000_0001};
		logic [3:0] ts[7] = '{4'hF, 4'h1, 4'hC, 4'h3, 4'h3, 4'hF, 4'h3};
		logic [31:0] te[7] = '{32'h0000_803F, 32'h0000_803F, 32'h0000_803F, 0,
			32'h0000_0002, 32'h0000_0001, 0};
		apb(0, ADDR_CFG, 0, 4'hF);
		`CHK(rd, 32'h0000_0020)
		apb(0, ADDR_PHY, 0, 4'hF);
		`CHK(rd, 32'h0000_0001)
		apb(0, 8'h18, 0, 4'hF);
		`CHK(er, 1'b1)
		for (k = 0; k < 7; k++) begin
			apb(1, ta[k], td[k], ts[k]);
			apb(0, ADDR_CFG, 0, 4'hF);
			`CHK(rd, te[k])
		end
	endtask : t_regs
	task automatic t_div;
		int dv[11] = '{4, 4, 6, 8, 10, 14, 20, 28, 40, 48, 50};
		for (k = 0; k < 11; k++) begin
			apb(1, ADDR_CFG, 32'(k << 2), 4'h3);
			rise(n);
			rise(n);
			`CHK(n, dv[k])
		end
	endtask : t_div
	task automatic t_soft;
		apb(1, ADDR_CFG, 32'h0000_8020, 4'h3);
		n = 0;
		repeat (3) @(posedge pclk);
		repeat (100) begin
			@(posedge pclk);
			if (mdc !== 1'b0 || mdio_oe !== 1'b0) n++;
		end
		`CHK(n, 0)
		apb(1, ADDR_CFG, 32'h0000_0020, 4'h3);
	endtask : t_soft
	task automatic t_pre;
		for (int p = 0; p < 2; p++) begin
			apb(1, ADDR_CFG, 32'h0000_0020 | 32'(p << 1), 4'h3);
			scan_enable <= 1'b1;
			wt(1);
			for (k = 0; k < 40; k++) begin
				rise(n);
				if (mdio_out !== 1'b1) break;
			end
			`CHK(k, p ? 0 : 32)
			scan_enable <= 1'b0;
			wt(0);
			// Let the frame finish; the partner answers its seed rotated left by two
			for (n = 0; n < 5000 && read_valid !== 1'b1; n++) @(posedge pclk);
			`CHK(read_valid, 1'b1)
			`CHK(read_data, 16'h970E)
		end
	endtask : t_pre
	task automatic t_scan;
		apb(1, ADDR_PHY, 32'h0000_0003, 4'h3);
		apb(1, ADDR_CFG, 32'h0000_0023, 4'h3);
		scan_enable <= 1'b1;
		for (k = 0; k < 4; k++) begin
			wt(0);
			wt(1);
			`CHK(scan_phy, 5'(k % 3 + 1))
		end
		scan_enable <= 1'b0;
	endtask : t_scan
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			report_and_stop;
		end
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_div;
		t_soft;
		t_pre;
		t_scan;
		report_and_stop;
	end
endmodule : tb_mmc_top
`default_nettype wire
